// >>> inc/ded_map.vh
// Register map, field positions and reset values of the debug event detector.
// Included by the detector and its comparator; definitions only.
`ifndef DED_MAP_VH
`define DED_MAP_VH
// Word byte offsets on the register bus
`define DED_CTL0_OFF 8'h00
`define DED_CTL1_OFF 8'h04
`define DED_CTL2_OFF 8'h08
`define DED_STAT_OFF 8'h0C
`define DED_ICA0_OFF 8'h10
`define DED_ICA1_OFF 8'h14
`define DED_ICA2_OFF 8'h18
`define DED_ICA3_OFF 8'h1C
`define DED_DCA0_OFF 8'h20
`define DED_DCA1_OFF 8'h24
`define DED_DVL0_OFF 8'h28
`define DED_DVL1_OFF 8'h2C
// debug_control_zero enable bits
`define DED_EN_ICA 0
`define DED_EN_DCA 4
`define DED_EN_DVL 5
`define DED_EN_BRT 6
`define DED_EN_TRP 7
`define DED_EN_RET 8
`define DED_EN_CMP 9
`define DED_EN_IRQ 10
`define DED_EN_MODE 12
// debug_control_one fields
`define DED_MODE_A 0
`define DED_MODE_B 2
`define DED_FLIP_A 4
`define DED_FLIP_B 5
`define DED_PRIV 8
// debug_control_two fields
`define DED_DC_EN0 0
`define DED_DC_EN1 1
`define DED_DC_RNG 2
// debug_status_reg bits
`define DED_ST_ICA 0
`define DED_ST_DCA 4
`define DED_ST_DVL 5
`define DED_ST_BRT 6
`define DED_ST_TRP 7
`define DED_ST_RET 8
`define DED_ST_CMP 9
`define DED_ST_IRQ 10
`define DED_ST_FRC 11
`define DED_ST_FLA 12
`define DED_ST_FLB 13
// Encodings
`define DED_MD_EXACT 2'h0
`define DED_MD_INCL 2'h2
`define DED_MD_EXCL 2'h3
`define DED_PV_ANY 2'h0
`define DED_PV_SUP 2'h2
`define DED_PV_USR 2'h3
`define DED_RST_VAL 32'h00000000
`endif

// >>> core/ded_pair.v
// One comparator pair: exact or range compare with privilege and auto flip.
// Assumes the addresses and controls are stable register outputs.
`timescale 1ns/10ps
`include "ded_map.vh"
module ded_pair #(
  parameter AW = 32
) (
  input wire [AW-1:0] inst_addr, // Address about to execute
  input wire user_state_flag, // 1 in user state
  input wire [AW-1:0] lo_addr, // Lower compare register
  input wire [AW-1:0] hi_addr, // Upper compare register
  input wire [1:0] mode, // Pair compare mode
  input wire [1:0] en, // Per comparator enables
  input wire [3:0] priv, // Two privilege qualifiers
  input wire flip_en, // Range auto flip enable
  input wire flip_state, // Range auto flip state
  output reg [1:0] hit // Per comparator events
);
  reg [1:0] eff_mode;
  reg [1:0] pv_ok;
  reg in_rng;
  integer i;
  // Privilege qualifier and compare selection
  always @*
  begin
    eff_mode = mode;
    if (flip_en && flip_state && mode[1])
      eff_mode = {1'b1, ~mode[0]};
    for (i = 0; i < 2; i = i + 1)
    begin
      case (priv[2*i +: 2])
        `DED_PV_ANY: pv_ok[i] = 1'b1;
        `DED_PV_SUP: pv_ok[i] = ~user_state_flag;
        `DED_PV_USR: pv_ok[i] = user_state_flag;
        default: pv_ok[i] = 1'b0; // Reserved code never fires
      endcase
    end
    in_rng = (inst_addr >= lo_addr) && (inst_addr < hi_addr);
    case (eff_mode)
      `DED_MD_EXACT: hit = en & pv_ok &
        {inst_addr == hi_addr, inst_addr == lo_addr};
      `DED_MD_INCL: hit = in_rng ? (en & pv_ok) : 2'h0;
      `DED_MD_EXCL: hit = in_rng ? 2'h0 : (en & pv_ok);
      default: hit = 2'h0; // Mask mode unsupported
    endcase
  end
endmodule

// >>> core/ded_top.v
// Debug event detector: nine event kinds, four instruction comparators,
// data address and value compare, sticky status over classic Wishbone.
// Assumes pipeline event strobes are one-cycle pulses on core_clk.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`include "ded_map.vh"
// Behaviour
// - Events gated by enables, recorded in status
// - Instruction address match flagged before execution
// - Data address match on load store cache
// - Value match needs address match too
// - Branch event only when branch redirects
// - Trap event when trap condition true
// - Exit event on any interrupt return
// - Completion and interrupt taken events raised
// - Forced event needs no enable
// - Four comparators, exact or paired ranges
// - Per comparator enable and status bit
// - Mode 00 exact match per comparator
// - Mode 10 inclusive from lower up to, not including, upper
// - Mode 11 exclusive outside the range
// - Range hit sets enabled comparators' status
// - Privilege qualifier any, supervisor, user
// - Auto flip inverts state, swaps modes
// - Without debug mode only record, trace
module ded_top #(
  parameter AW = 32, // Instruction and data address width
  parameter DW = 32 // Referenced data width
) (
  input wire core_clk, // Core clock
  input wire rst_n, // Synchronous reset, active low
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  output wire wb_err_o, // Wishbone error, tied low; a map hole is acked
  input wire inst_valid, // Instruction about to execute
  input wire [AW-1:0] inst_addr, // Its address
  input wire user_state_flag, // Problem state of the machine
  input wire ls_valid, // Load store or cache op attempted
  input wire [AW-1:0] ls_addr, // Its data address
  input wire [DW-1:0] ls_data, // Data it references
  input wire branch_taken, // Branch redirected stream
  input wire trap_true, // Trap conditions met
  input wire rfi_any, // One of three interrupt returns
  input wire inst_done, // Instruction completed
  input wire irq_taken, // Interrupt generated
  input wire force_req, // Forced debug request from scan port
  output reg [10:0] trace_evt, // Event pulses for trace; bit 10 is interrupt taken or forced request
  output wire stop_req, // Stop request when a debug mode is on
  output wire [31:0] debug_status_reg // Status view
);
  reg [31:0] ctl0_q;
  reg [31:0] ctl1_q;
  reg [31:0] ctl2_q;
  reg [31:0] stat_q;
  reg [31:0] stat_d;
  reg [AW-1:0] ica_q [0:3];
  reg [AW-1:0] dca_q [0:1];
  reg [DW-1:0] dvl_q [0:1];
  reg [3:0] ica_hit;
  reg [10:0] evt;
  reg dc_hit;
  reg [31:0] rd_mux;
  reg hit_map;
  wire [1:0] hit_a;
  wire [1:0] hit_b;
  wire wr_stb;
  wire [31:0] wmask;
  wire [1:0] dc_eq;
  wire dc_in;
  // Byte lane mask from selects
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Writes land on the edge at which the master samples ack high, never earlier
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && hit_map;
  assign wb_err_o = 1'b0;
  assign debug_status_reg = stat_q;
  // Pair comparators; pair a is 1 with 2, pair b is 3 with 4
  ded_pair #(.AW(AW)) u_pair_a (
    .inst_addr(inst_addr),
    .user_state_flag(user_state_flag),
    .lo_addr(ica_q[0]),
    .hi_addr(ica_q[1]),
    .mode(ctl1_q[`DED_MODE_A +: 2]),
    .en(ctl0_q[`DED_EN_ICA +: 2]),
    .priv(ctl1_q[`DED_PRIV +: 4]),
    .flip_en(ctl1_q[`DED_FLIP_A]),
    .flip_state(stat_q[`DED_ST_FLA]),
    .hit(hit_a)
  );
  ded_pair #(.AW(AW)) u_pair_b (
    .inst_addr(inst_addr),
    .user_state_flag(user_state_flag),
    .lo_addr(ica_q[2]),
    .hi_addr(ica_q[3]),
    .mode(ctl1_q[`DED_MODE_B +: 2]),
    .en(ctl0_q[`DED_EN_ICA + 2 +: 2]),
    .priv(ctl1_q[`DED_PRIV + 4 +: 4]),
    .flip_en(ctl1_q[`DED_FLIP_B]),
    .flip_state(stat_q[`DED_ST_FLB]),
    .hit(hit_b)
  );
  // Data address compare: either register exact, or range 0..1
  assign dc_eq = {ls_addr == dca_q[1], ls_addr == dca_q[0]};
  assign dc_in = (ls_addr >= dca_q[0]) && (ls_addr < dca_q[1]);
  // Event detection, each gated by its own enable except the forced one
  always @*
  begin
    ica_hit = inst_valid ? {hit_b, hit_a} : 4'h0;
    if (ctl2_q[`DED_DC_RNG])
      dc_hit = ls_valid && dc_in && (ctl2_q[`DED_DC_EN0] || ctl2_q[`DED_DC_EN1]);
    else
      dc_hit = ls_valid && |(dc_eq & ctl2_q[`DED_DC_EN0 +: 2]);
    evt = 11'h000;
    evt[3:0] = ica_hit;
    evt[4] = dc_hit && ctl0_q[`DED_EN_DCA];
    evt[5] = dc_hit && ctl0_q[`DED_EN_DVL] &&
      (ls_data == dvl_q[0] || ls_data == dvl_q[1]);
    evt[6] = branch_taken && ctl0_q[`DED_EN_BRT];
    evt[7] = trap_true && ctl0_q[`DED_EN_TRP];
    evt[8] = rfi_any && ctl0_q[`DED_EN_RET];
    evt[9] = inst_done && ctl0_q[`DED_EN_CMP];
    evt[10] = irq_taken && ctl0_q[`DED_EN_IRQ];
  end
  // Trace pulses always; stop only with a debug mode enabled
  assign stop_req = ctl0_q[`DED_EN_MODE] && (|stat_q[11:0]);
  // Address decode and read mux
  always @*
  begin
    hit_map = 1'b1;
    case (wb_adr_i)
      `DED_CTL0_OFF: rd_mux = ctl0_q;
      `DED_CTL1_OFF: rd_mux = ctl1_q;
      `DED_CTL2_OFF: rd_mux = ctl2_q;
      `DED_STAT_OFF: rd_mux = stat_q;
      `DED_ICA0_OFF: rd_mux = ica_q[0];
      `DED_ICA1_OFF: rd_mux = ica_q[1];
      `DED_ICA2_OFF: rd_mux = ica_q[2];
      `DED_ICA3_OFF: rd_mux = ica_q[3];
      `DED_DCA0_OFF: rd_mux = dca_q[0];
      `DED_DCA1_OFF: rd_mux = dca_q[1];
      `DED_DVL0_OFF: rd_mux = dvl_q[0];
      `DED_DVL1_OFF: rd_mux = dvl_q[1];
      default:
      begin
        rd_mux = 32'h00000000;
        hit_map = 1'b0; // Unmapped: acked, reads zero, writes dropped
      end
    endcase
  end
  // Status next value: write-one-to-clear, a new event wins over the clear
  always @*
  begin
    stat_d = stat_q;
    if (wr_stb && wb_adr_i == `DED_STAT_OFF)
      stat_d = stat_q & ~(wb_dat_i & wmask);
    stat_d[10:0] = stat_d[10:0] | evt;
    if (force_req)
      stat_d[`DED_ST_FRC] = 1'b1;
    if (ctl1_q[`DED_FLIP_A] && |ica_hit[1:0])
      stat_d[`DED_ST_FLA] = ~stat_q[`DED_ST_FLA];
    if (ctl1_q[`DED_FLIP_B] && |ica_hit[3:2])
      stat_d[`DED_ST_FLB] = ~stat_q[`DED_ST_FLB];
    stat_d[31:14] = 18'h00000;
  end
  // Registers, bus answer and trace pulses
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctl0_q <= `DED_RST_VAL;
      ctl1_q <= `DED_RST_VAL;
      ctl2_q <= `DED_RST_VAL;
      stat_q <= `DED_RST_VAL;
      ica_q[0] <= {AW{1'b0}};
      ica_q[1] <= {AW{1'b0}};
      ica_q[2] <= {AW{1'b0}};
      ica_q[3] <= {AW{1'b0}};
      dca_q[0] <= {AW{1'b0}};
      dca_q[1] <= {AW{1'b0}};
      dvl_q[0] <= {DW{1'b0}};
      dvl_q[1] <= {DW{1'b0}};
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      trace_evt <= 11'h000;
    end
    else
    begin
      stat_q <= stat_d;
      trace_evt <= {force_req, 10'h000} | evt;
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_mux;
      if (wr_stb)
      begin
        case (wb_adr_i)
          `DED_CTL0_OFF: ctl0_q <= (ctl0_q & ~wmask) | (wb_dat_i & wmask);
          `DED_CTL1_OFF: ctl1_q <= (ctl1_q & ~wmask) | (wb_dat_i & wmask);
          `DED_CTL2_OFF: ctl2_q <= (ctl2_q & ~wmask) | (wb_dat_i & wmask);
          `DED_ICA0_OFF: ica_q[0] <= (ica_q[0] & ~wmask) | (wb_dat_i & wmask);
          `DED_ICA1_OFF: ica_q[1] <= (ica_q[1] & ~wmask) | (wb_dat_i & wmask);
          `DED_ICA2_OFF: ica_q[2] <= (ica_q[2] & ~wmask) | (wb_dat_i & wmask);
          `DED_ICA3_OFF: ica_q[3] <= (ica_q[3] & ~wmask) | (wb_dat_i & wmask);
          `DED_DCA0_OFF: dca_q[0] <= (dca_q[0] & ~wmask) | (wb_dat_i & wmask);
          `DED_DCA1_OFF: dca_q[1] <= (dca_q[1] & ~wmask) | (wb_dat_i & wmask);
          `DED_DVL0_OFF: dvl_q[0] <= (dvl_q[0] & ~wmask) | (wb_dat_i & wmask);
          `DED_DVL1_OFF: dvl_q[1] <= (dvl_q[1] & ~wmask) | (wb_dat_i & wmask);
          default: ctl0_q <= ctl0_q;
        endcase
      end
    end
  end
endmodule

// >>> tb/ded_top_assertions.sv
// Checker for the debug event detector, bound to its top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/10ps
module ded_top_assertions (
  input wire core_clk, // Clock
  input wire rst_n, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire wb_ack_o, // Ack
  input wire branch_taken, // Branch
  input wire trap_true, // Trap
  input wire inst_done, // Completion
  input wire force_req, // Forced request
  input wire [10:0] trace_evt, // Trace pulses
  input wire stop_req, // Stop request
  input wire [31:0] debug_status_reg // Status
);
  // One domain, so one clock and reset for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_force_rec: assert property (force_req |=> debug_status_reg[11] && trace_evt[10])
    else $error("forced event lost");
  chk_status_sticky: assert property (
    !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h0C)
    |=> (~debug_status_reg & $past(debug_status_reg) & 32'h00000FFF) == 32'h0)
    else $error("status bit lost");
  chk_trace_rec: assert property ((trace_evt[9:0] & ~debug_status_reg[9:0]) == 10'h000)
    else $error("trace without status");
  chk_stop_quiet: assert property (debug_status_reg[11:0] == 12'h000 |-> !stop_req)
    else $error("stop without event");
  chk_brt_cause: assert property (trace_evt[6] |-> $past(branch_taken))
    else $error("branch event uncaused");
  chk_trap_cause: assert property (trace_evt[7] |-> $past(trap_true))
    else $error("trap event uncaused");
  chk_cmp_cause: assert property (trace_evt[9] |-> $past(inst_done))
    else $error("completion uncaused");
endmodule
bind ded_top ded_top_assertions chk (.core_clk(core_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .branch_taken(branch_taken), .trap_true(trap_true),
  .inst_done(inst_done), .force_req(force_req), .trace_evt(trace_evt),
  .stop_req(stop_req), .debug_status_reg(debug_status_reg));

// >>> tb/ded_pipe_model.sv
// Stand-in for the pipeline and the scan debug controller.
// Assumes pulse() is called just after a rising clock edge.
`timescale 1ns/10ps
module ded_pipe_model #(
  parameter AW = 32
) (
  input wire core_clk, // Clock
  output reg [7:0] ev, // Inst ls brt trap ret done irq force
  output reg [AW-1:0] addr, // Address
  output reg user_flag // User state
);
  // Quiet from time zero
  initial
  begin
    ev = 8'h00;
    addr = {AW{1'b0}};
    user_flag = 1'b0;
  end
  // Strobe one cycle, then idle; released address inverted so it never matches stale
  task pulse(input integer k, input [AW-1:0] a, input u);
    begin
      ev <= 8'h01 << k;
      addr <= a;
      user_flag <= u;
      @(posedge core_clk);
      ev <= 8'h00;
      addr <= ~a;
      @(posedge core_clk);
    end
  endtask
endmodule

// >>> tb/ded_top_test.sv
// Self-checking bench for the debug event detector.
// Assumes the pipeline model supplies every event strobe.
`timescale 1ns/10ps
`include "ded_map.vh"
module ded_top_test;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg wen = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'hF;
  reg [31:0] wdat = 32'h0;
  reg [31:0] q;
  reg [31:0] exp_s;
  wire [31:0] rdat, addr, stat;
  wire [7:0] ev;
  wire ack, user_flag, stop_req;
  integer err_total = 0;
  integer checks = 0;
  integer i;
  // Cases: address and hits; three exact, then ranges
  localparam [127:0] ta_tab = 128'h0200_0300_0304_0100_01FC_0200_0300_0400;
  localparam [31:0] te_tab = 32'h040DDC0C;
  initial forever #4 core_clk = ~core_clk;
  ded_pipe_model pipe (.core_clk(core_clk), .ev(ev), .addr(addr), .user_flag(user_flag));
  ded_top dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(), .inst_valid(ev[0]), .inst_addr(addr),
    .user_state_flag(user_flag), .ls_valid(ev[1]), .ls_addr(addr), .ls_data(addr),
    .branch_taken(ev[2]), .trap_true(ev[3]), .rfi_any(ev[4]), .inst_done(ev[5]),
    .irq_taken(ev[6]), .force_req(ev[7]), .trace_evt(), .stop_req(stop_req),
    .debug_status_reg(stat));
  task check(input [31:0] got, input [31:0] want);
    begin
      checks = checks + 1;
      if (got !== want)
      begin
        err_total = err_total + 1;
        $display("wrong value at %0t: %h not %h", $time, got, want);
      end
    end
  endtask
  // Hold request until ack seen at an edge, then one idle cycle
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= w;
      adr <= a;
      wdat <= d;
      // Ends when ack is high; only the watchdog ends a hang
      while (ack !== 1'b1)
        @(posedge core_clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(q, e);
    end
  endtask
  task ica(input [31:0] b, input [31:0] s);
    integer n;
    for (n = 0; n < 4; n = n + 1)
      wr(`DED_ICA0_OFF + {n[5:0], 2'b00}, b + s * n);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Whole run is near 300 cycles
  initial
  begin
    #100000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 12; i = i + 1)
      rd({i[5:0], 2'b00}, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    // One byte lane only
    sel <= 4'h2;
    wr(`DED_DCA1_OFF, 32'hA5A5A5A5);
    sel <= 4'hF;
    rd(`DED_DCA1_OFF, 32'h0000A500);
    wr(`DED_DCA1_OFF, 32'h0);
    $display("test map done");
    // Nothing enabled: only the forced request lands
    for (i = 0; i < 8; i = i + 1)
      pipe.pulse(i, 32'h0, 1'b0);
    rd(`DED_STAT_OFF, 32'h00000800);
    wr(`DED_STAT_OFF, 32'hFFFFFFFF);
    wr(`DED_CTL0_OFF, 32'h000007F0);
    wr(`DED_CTL2_OFF, 32'h00000001);
    wr(`DED_DCA0_OFF, 32'h00000800);
    wr(`DED_DVL0_OFF, 32'h00000800);
    pipe.pulse(1, 32'h00000804, 1'b0);
    rd(`DED_STAT_OFF, 32'h0);
    pipe.pulse(1, 32'h00000800, 1'b0);
    exp_s = 32'h00000030;
    rd(`DED_STAT_OFF, exp_s);
    for (i = 2; i < 7; i = i + 1)
    begin
      pipe.pulse(i, 32'h0, 1'b0);
      exp_s = exp_s | (32'h1 << (i + 4));
      rd(`DED_STAT_OFF, exp_s);
    end
    check({31'h0, stop_req}, 32'h0);
    wr(`DED_STAT_OFF, 32'h00000040);
    rd(`DED_STAT_OFF, exp_s & ~32'h40);
    $display("test events done");
    wr(`DED_CTL0_OFF, 32'h0000000D);
    wr(`DED_STAT_OFF, 32'hFFFFFFFF);
    ica(32'h100, 32'h100);
    for (i = 0; i < 8; i = i + 1)
    begin
      if (i == 3)
        wr(`DED_CTL1_OFF, 32'h0000000E);
      pipe.pulse(0, {16'h0, ta_tab[127 - 16 * i -: 16]}, 1'b0);
      rd(`DED_STAT_OFF, {28'h0, te_tab[31 - 4 * i -: 4]});
      wr(`DED_STAT_OFF, 32'hFFFFFFFF);
    end
    $display("test compare done");
    ica(32'h100, 32'h0);
    wr(`DED_CTL1_OFF, 32'h00000E00);
    wr(`DED_CTL0_OFF, 32'h00000007);
    for (i = 0; i < 2; i = i + 1)
    begin
      pipe.pulse(0, 32'h100, i[0]);
      rd(`DED_STAT_OFF, i ? 32'h6 : 32'h5);
      wr(`DED_STAT_OFF, 32'hFFFFFFFF);
    end
    $display("test privilege done");
    ica(32'h100, 32'h100);
    wr(`DED_CTL1_OFF, 32'h00000012);
    wr(`DED_CTL0_OFF, 32'h00000001);
    pipe.pulse(0, 32'h150, 1'b0);
    rd(`DED_STAT_OFF, 32'h00001001);
    wr(`DED_STAT_OFF, 32'h00000001);
    pipe.pulse(0, 32'h150, 1'b0);
    rd(`DED_STAT_OFF, 32'h00001000);
    pipe.pulse(0, 32'h250, 1'b0);
    rd(`DED_STAT_OFF, 32'h00000001);
    wr(`DED_CTL0_OFF, 32'h00001001);
    check({31'h0, stop_req}, 32'h1);
    $display("test flip done");
    print_verdict;
  end
endmodule
